/* verilog/usp_consts.svh */
`ifndef USP_CONSTS_SVH
`define USP_CONSTS_SVH

// Packet and buffer geometry, in bytes; FIFO width in bits, depth in entries
`define USP_MPS_LAST      6'h3F
`define USP_BUF_BYTES     11'h600
`define USP_STD_FRAME     11'h5EA
`define USP_MAX_FRAME     11'h5FC
`define USP_FCS_BYTES     11'h004
`define USP_FIFO_WIDTH    10
`define USP_FIFO_DEPTH    8

// Frame check sequence
`define USP_CRC_INIT      32'hFFFF_FFFF
`define USP_CRC_POLY      32'hEDB8_8320
`define USP_CRC_RESIDUE   32'hDEBB_20E3

// Reset values
`define USP_DATA_PROTOCOL 8'h00
`define USP_CNT_RST       16'h0000
`define USP_LEN_RST       11'h000

`endif

/* verilog/usp_pkg.sv */
`include "usp_consts.svh"

package usp_pkg;

  typedef enum logic [1:0] {
    USP_RX_IDLE = 2'h0,
    USP_RX_FILL = 2'h1,
    USP_RX_SEND = 2'h3,
    USP_RX_ZLP  = 2'h2
  } usp_rx_state_type;

  typedef enum logic [1:0] {
    USP_TX_COLLECT = 2'h0,
    USP_TX_DATA    = 2'h1,
    USP_TX_FCS     = 2'h3,
    USP_TX_DROP    = 2'h2
  } usp_tx_state_type;

  typedef struct packed {
    logic [1:0]       rst_sync;
    usp_rx_state_type rx_st;
    logic [10:0]      rx_cnt;
    logic             rx_ovf;
    logic [31:0]      rx_crc;
    logic [10:0]      rx_len;
    logic [10:0]      rd_ptr;
    logic [5:0]       in_pkt;
    usp_tx_state_type tx_st;
    logic [10:0]      tx_cnt;
    logic [10:0]      tx_len;
    logic [5:0]       out_pkt;
    logic [31:0]      tx_crc;
    logic [1:0]       fcs_idx;
    logic             active;
    logic [10:0]      seg_max;
    logic [7:0]       proto;
    logic             in_valid;
    logic [7:0]       in_data;
    logic             in_last;
    logic             in_zlp;
    logic             out_ready;
    logic             tx_valid;
    logic [7:0]       tx_data;
    logic             tx_last;
    logic             notify_conn;
    logic             notify_speed;
    logic             out_stall;
    logic             iso_err;
    logic             stat_valid;
    logic [10:0]      stat_len;
    logic             stat_good;
    logic [15:0]      frames;
    logic [15:0]      drops;
  } usp_state_type;

  // Reflected CRC-32, one byte, LSB first as on the wire
  function automatic logic [31:0] usp_crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `USP_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : usp_crc_byte

endpackage : usp_pkg

/* verilog/usp_segment_pipe.sv */
`include "usp_consts.svh"

module usp_fifo #(
  parameter int WIDTH = `USP_FIFO_WIDTH,
  parameter int DEPTH = `USP_FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             clr,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } usp_fifo_state_type;

  usp_fifo_state_type q;
  usp_fifo_state_type n;
  logic               full;
  logic               empty;

  // Extra pointer bit tells full from empty without a counter
  assign full      = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign empty     = q.wp == q.rp;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = q.mem[q.rp[AW-1:0]];

  always_comb begin
    n = q;
    if (clr) begin
      n.wp = '0;
      n.rp = '0;
    end else begin
      if (in_valid && !full) begin
        n.mem[q.wp[AW-1:0]] = in_data;
        n.wp                = q.wp + 1'b1;
      end
      if (out_ready && !empty) begin
        n.rp = q.rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule : usp_fifo

// What this block does
// RULE_01: Many bulk packets per USB frame allowed
// RULE_02: Data interface protocol code reads zero
// RULE_03: Default setting passes no traffic at all; a frame already in transmit still finishes to the MAC
// RULE_04: Alternate setting opens one IN, one OUT
// RULE_05: Reselection flushes, clears counters, notifies host; code does so only on leaving setting 0, not between alternate settings
// RULE_06: Packets before last are full size
// RULE_07: Short packet closes the current segment
// RULE_08: Full final packet gets zero-length follower
// RULE_09: Host sends zero-length write when needed
// RULE_10: Segment limit agreed, bounded by buffer
// RULE_11: No checksum carried over USB endpoints
// RULE_12: Append checksum out, verify checksum in
// RULE_13: Whole frame held; bad checksum never forwarded
// RULE_14: 1514-byte frames, longer when negotiated
// RULE_15: Buffered frame sent only on host demand
// RULE_16: Status entry kept alongside each buffer
// RULE_17: Isochronous reports errors, no retry, no flow
// RULE_18: Under-64 or zero-length packet ends frame
// RULE_19: Memory exhausted mid-frame releases whole frame
// RULE_20: Bad-checksum frame space freed at once
module usp_segment_pipe
  import usp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [1:0]  alt_setting,
  input  wire logic        iso_mode,
  input  wire logic [10:0] seg_limit,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  output logic             in_valid,
  output logic      [7:0]  in_data,
  output logic             in_last,
  output logic             in_zlp,
  input  wire logic        in_ready,
  input  wire logic        out_valid,
  input  wire logic [7:0]  out_data,
  input  wire logic        out_eop,
  input  wire logic        out_zlp,
  output logic             out_ready,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  output logic             tx_last,
  input  wire logic        tx_ready,
  output logic      [7:0]  data_protocol,
  output logic      [10:0] seg_max,
  output logic             notify_conn,
  output logic             notify_speed,
  output logic             out_stall,
  output logic             iso_err,
  output logic             stat_valid,
  output logic      [10:0] stat_len,
  output logic             stat_good,
  output logic      [15:0] stat_frames,
  output logic      [15:0] stat_drops
);

  usp_state_type q;
  usp_state_type n;
  logic [1:0]    rst_q;
  logic          rst_n;
  logic [7:0]    rx_mem [0:`USP_BUF_BYTES-1];
  logic [7:0]    tx_mem [0:`USP_BUF_BYTES-1];
  logic          rx_we;
  logic          tx_we;
  logic [10:0]   lim;
  logic [31:0]   crc_n;
  logic [31:0]   fcs;
  logic          capture;
  logic          good;
  logic          last_byte;
  logic          take;
  logic          seg_end;
  logic          ovf;
  logic          f_push;
  logic [9:0]    f_wdata;
  logic          f_iready;
  logic          f_ovalid;
  logic [9:0]    f_rdata;
  logic          f_pop;
  logic          f_clr;

  // Reset enters asynchronously on assert, leaves synchronously on release
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  usp_fifo #(
    .WIDTH(`USP_FIFO_WIDTH),
    .DEPTH(`USP_FIFO_DEPTH)
  ) u_in_fifo (
    .clock    (clock),
    .rst_n    (rst_n),
    .clr      (f_clr),
    .in_valid (f_push),
    .in_data  (f_wdata),
    .in_ready (f_iready),
    .out_valid(f_ovalid),
    .out_data (f_rdata),
    .out_ready(f_pop)
  );

  // Buffers hold data only, no reset needed
  always_ff @(posedge clock) begin
    if (rx_we) begin
      rx_mem[q.rx_cnt] <= rx_data;
    end
    if (tx_we) begin
      tx_mem[q.tx_cnt] <= out_data;
    end
  end

  always_comb begin
    n              = q;
    n.rst_sync     = 2'h0;
    rx_we          = 1'b0;
    tx_we          = 1'b0;
    f_push         = 1'b0;
    f_wdata        = 10'h000;
    f_clr          = 1'b0;
    good           = 1'b0;
    last_byte      = 1'b0;
    ovf            = 1'b0;
    crc_n          = usp_crc_byte(q.rx_crc, rx_data);
    fcs            = ~q.tx_crc;
    n.notify_conn  = 1'b0;
    n.notify_speed = 1'b0;
    n.out_stall    = 1'b0;
    n.iso_err      = 1'b0;
    n.stat_valid   = 1'b0;
    n.proto        = `USP_DATA_PROTOCOL;                                  // [RULE_02]
    // Standard frames always fit; longer only as far as the buffer allows
    lim = (seg_limit > `USP_MAX_FRAME) ? `USP_MAX_FRAME : seg_limit;       // [RULE_14]
    if (lim < `USP_STD_FRAME) begin
      lim = `USP_STD_FRAME;
    end
    n.seg_max = lim;                                                       // [RULE_10]
    n.active  = alt_setting != 2'h0;                                       // [RULE_03] [RULE_04]
    capture   = rx_valid && (q.rx_st == USP_RX_FILL || (q.rx_st == USP_RX_IDLE && q.active));
    take      = out_valid && q.out_ready;
    seg_end   = out_zlp || (out_eop && q.out_pkt != `USP_MPS_LAST);        // [RULE_07] [RULE_18]
    f_pop     = f_ovalid && q.active && (!q.in_valid || in_ready);         // [RULE_03] [RULE_15]

    if (!q.active && n.active) begin
      // Leaving the default setting restarts the whole pipe
      n.rx_st        = USP_RX_IDLE;                                        // [RULE_05]
      n.tx_st        = USP_TX_COLLECT;
      n.tx_cnt       = `USP_LEN_RST;
      n.out_pkt      = 6'h00;
      n.in_valid     = 1'b0;
      n.tx_valid     = 1'b0;
      n.tx_last      = 1'b0;
      n.frames       = `USP_CNT_RST;
      n.drops        = `USP_CNT_RST;
      n.notify_conn  = 1'b1;
      n.notify_speed = 1'b1;
      f_clr          = 1'b1;
      f_pop          = 1'b0;
    end else begin
      // Receive side: whole frame lands before anything is forwarded
      if (capture) begin
        rx_we    = q.rx_cnt < (lim + `USP_FCS_BYTES);                     // [RULE_13]
        n.rx_crc = crc_n;                                                  // [RULE_12]
        n.rx_ovf = q.rx_ovf | ~rx_we;
        n.rx_cnt = rx_we ? q.rx_cnt + 11'h001 : q.rx_cnt;
        n.rx_st  = USP_RX_FILL;
        if (rx_last) begin
          good         = (crc_n == `USP_CRC_RESIDUE) && !n.rx_ovf && (n.rx_cnt > `USP_FCS_BYTES);
          n.stat_valid = 1'b1;                                             // [RULE_16]
          n.stat_good  = good;
          n.stat_len   = n.rx_cnt - `USP_FCS_BYTES;                        // [RULE_11]
          if (good) begin
            n.rx_len = n.rx_cnt - `USP_FCS_BYTES;
            n.rd_ptr = `USP_LEN_RST;
            n.in_pkt = 6'h00;
            n.rx_st  = USP_RX_SEND;
            n.frames = q.frames + 16'h0001;
          end else begin
            n.rx_st = USP_RX_IDLE;                                         // [RULE_13] [RULE_20]
            n.drops = q.drops + 16'h0001;
          end
        end
      end else if (rx_valid && rx_last && q.rx_st != USP_RX_FILL) begin
        // One buffer only: frames meeting a busy or closed pipe are lost
        n.drops = q.drops + 16'h0001;
      end

      // Segmentation into IN packets, paced by the FIFO
      if (q.rx_st == USP_RX_SEND && q.active && f_iready) begin
        last_byte = q.rd_ptr == (q.rx_len - 11'h001);
        f_push    = 1'b1;
        f_wdata   = {1'b0, last_byte || q.in_pkt == `USP_MPS_LAST, rx_mem[q.rd_ptr]}; // [RULE_06]
        n.rd_ptr  = q.rd_ptr + 11'h001;
        n.in_pkt  = q.in_pkt + 6'h01;
        if (last_byte) begin
          n.rx_st = (q.in_pkt == `USP_MPS_LAST) ? USP_RX_ZLP : USP_RX_IDLE;
        end
      end else if (q.rx_st == USP_RX_ZLP && q.active && f_iready) begin
        f_push  = 1'b1;
        f_wdata = {1'b1, 1'b1, 8'h00};                                     // [RULE_08]
        n.rx_st = USP_RX_IDLE;
      end

      // Output stage; no per-frame cap, host may pull back to back
      if (f_pop) begin
        {n.in_zlp, n.in_last, n.in_data} = f_rdata;                        // [RULE_01]
        n.in_valid                       = 1'b1;
      end else if (in_ready) begin
        n.in_valid = 1'b0;
      end

      // Transmit side
      if (q.tx_valid && tx_ready) begin
        n.tx_valid = 1'b0;
        n.tx_last  = 1'b0;
      end
      unique case (q.tx_st)
        USP_TX_COLLECT: begin
          if (take) begin
            if (!out_zlp) begin
              if (q.tx_cnt == `USP_BUF_BYTES) begin
                // Out of buffer: give back everything this frame held
                ovf      = 1'b1;
                n.tx_cnt = `USP_LEN_RST;                                   // [RULE_19]
                n.drops  = q.drops + 16'h0001;
                // Isochronous has no stall to retry with, so only report
                n.out_stall = !iso_mode;
                n.iso_err   = iso_mode;                                    // [RULE_17]
                n.tx_st     = seg_end ? USP_TX_COLLECT : USP_TX_DROP;
              end else begin
                tx_we    = 1'b1;
                n.tx_cnt = q.tx_cnt + 11'h001;
              end
              n.out_pkt = out_eop ? 6'h00 : q.out_pkt + 6'h01;
            end
            if (seg_end) begin
              n.out_pkt = 6'h00;
              if (!ovf && n.tx_cnt != `USP_LEN_RST) begin
                n.tx_len = n.tx_cnt;                                       // [RULE_07] [RULE_18]
                n.tx_cnt = `USP_LEN_RST;
                n.tx_crc = `USP_CRC_INIT;
                n.tx_st  = USP_TX_DATA;
              end
            end
          end
        end
        USP_TX_DROP: begin
          if (take) begin
            n.out_pkt = (out_eop || out_zlp) ? 6'h00 : q.out_pkt + 6'h01;
            if (seg_end) begin
              n.tx_st = USP_TX_COLLECT;
            end
          end
        end
        USP_TX_DATA: begin
          if (!q.tx_valid || tx_ready) begin
            n.tx_valid = 1'b1;
            n.tx_data  = tx_mem[q.tx_cnt];
            n.tx_last  = 1'b0;
            n.tx_crc   = usp_crc_byte(q.tx_crc, tx_mem[q.tx_cnt]);
            n.tx_cnt   = q.tx_cnt + 11'h001;
            if (q.tx_cnt == (q.tx_len - 11'h001)) begin
              n.fcs_idx = 2'h0;
              n.tx_st   = USP_TX_FCS;
            end
          end
        end
        USP_TX_FCS: begin
          if (!q.tx_valid || tx_ready) begin
            n.tx_valid = 1'b1;
            n.tx_data  = fcs[{q.fcs_idx, 3'b000} +: 8];                    // [RULE_12]
            n.tx_last  = q.fcs_idx == 2'h3;
            n.fcs_idx  = q.fcs_idx + 2'h1;
            if (q.fcs_idx == 2'h3) begin
              n.tx_cnt = `USP_LEN_RST;
              n.tx_st  = USP_TX_COLLECT;
            end
          end
        end
      endcase
    end

    if (n.rx_st == USP_RX_IDLE) begin
      n.rx_cnt = `USP_LEN_RST;
      n.rx_crc = `USP_CRC_INIT;
      n.rx_ovf = 1'b0;
    end
    n.out_ready = n.active && (n.tx_st == USP_TX_COLLECT || n.tx_st == USP_TX_DROP); // [RULE_03]
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q        <= '0;
      q.rx_crc <= `USP_CRC_INIT;
      q.tx_crc <= `USP_CRC_INIT;
      q.proto  <= `USP_DATA_PROTOCOL;
      q.seg_max <= `USP_STD_FRAME;
    end else begin
      q <= n;
    end
  end

  assign in_valid      = q.in_valid;
  assign in_data       = q.in_data;
  assign in_last       = q.in_last;
  assign in_zlp        = q.in_zlp;
  assign out_ready     = q.out_ready;
  assign tx_valid      = q.tx_valid;
  assign tx_data       = q.tx_data;
  assign tx_last       = q.tx_last;
  assign data_protocol = q.proto;
  assign seg_max       = q.seg_max;
  assign notify_conn   = q.notify_conn;
  assign notify_speed  = q.notify_speed;
  assign out_stall     = q.out_stall;
  assign iso_err       = q.iso_err;
  assign stat_valid    = q.stat_valid;
  assign stat_len      = q.stat_len;
  assign stat_good     = q.stat_good;
  assign stat_frames   = q.frames;
  assign stat_drops    = q.drops;
endmodule : usp_segment_pipe

/* testbench/usp_segment_pipe_chk.sv */
module usp_segment_pipe_chk (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [1:0]  alt_setting,
  input wire logic [10:0] seg_limit,
  input wire logic        rx_valid,
  input wire logic        rx_last,
  input wire logic        in_valid,
  input wire logic [7:0]  in_data,
  input wire logic        in_last,
  input wire logic        in_zlp,
  input wire logic        in_ready,
  input wire logic        out_valid,
  input wire logic        out_eop,
  input wire logic        out_zlp,
  input wire logic        out_ready,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_last,
  input wire logic        tx_ready,
  input wire logic [7:0]  data_protocol,
  input wire logic [10:0] seg_max,
  input wire logic        notify_conn,
  input wire logic        notify_speed,
  input wire logic        stat_valid,
  input wire logic [15:0] stat_frames,
  input wire logic [15:0] stat_drops
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0]  in_cnt_q;
  logic [5:0]  out_cnt_q;
  logic [10:0] lim_c;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // Clamp window mirrors the 1536-byte buffer less the checksum
  assign lim_c = (seg_limit < 11'h05EA) ? 11'h05EA : ((seg_limit > 11'h05FC) ? 11'h05FC : seg_limit);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      in_cnt_q  <= 6'h00;
      out_cnt_q <= 6'h00;
    end else begin
      if (in_valid && in_ready && !in_zlp) in_cnt_q <= in_last ? 6'h00 : in_cnt_q + 6'h01;
      if (out_valid && out_ready) out_cnt_q <= (out_eop || out_zlp) ? 6'h00 : out_cnt_q + 6'h01;
    end
  end

  sequence s_short_end;
    out_valid && out_ready && out_eop && !out_zlp && out_cnt_q < 6'h3F;
  endsequence
  sequence s_tx_start;
    !out_ready ##1 tx_valid;
  endsequence

  a_proto_zero: assert property (data_protocol == 8'h00)
    else $error("data protocol code not zero");
  a_idle_no_out: assert property (alt_setting == 2'h0 |=> !out_ready)
    else $error("OUT accepted in default setting");
  a_notify_pair: assert property ((notify_conn || notify_speed) |-> notify_conn && notify_speed
    && stat_frames == 16'h0000 && stat_drops == 16'h0000 && $past(alt_setting) != 2'h0)
    else $error("notify pulses or counter clear wrong");
  a_in_hold: assert property (in_valid && !in_ready |=> (in_valid && $stable(in_data) && $stable(in_last)) || notify_conn)
    else $error("IN element dropped before accepted");
  a_zlp_last: assert property (in_valid && in_zlp |-> in_last && in_cnt_q == 6'h00)
    else $error("zero-length element misplaced");
  a_in_full: assert property (in_valid && !in_zlp && in_cnt_q == 6'h3F |-> in_last)
    else $error("IN packet longer than max size");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("MAC byte changed before accepted");
  a_stat_cause: assert property (stat_valid |-> $past(rx_valid && rx_last))
    else $error("status entry without frame end");
  a_seg_clamp: assert property (seg_max == $past(lim_c))
    else $error("segment limit not clamped");
  a_short_end: assert property (s_short_end |=> s_tx_start)
    else $error("short packet did not close segment");
endmodule : usp_segment_pipe_chk

/* testbench/usp_host_model.sv */
module usp_host_model (
  input  wire logic       clock,
  input  wire logic       slow,
  input  wire logic       in_valid,
  output logic            in_ready,
  output logic            out_valid,
  output logic      [7:0] out_data,
  output logic            out_eop,
  output logic            out_zlp,
  input  wire logic       out_ready,
  output logic            stuck
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    in_ready  = 1'b0;
    out_valid = 1'b0;
    out_data  = 8'h00;
    out_eop   = 1'b0;
    out_zlp   = 1'b0;
    stuck     = 1'b0;
  end

  // Receiver side stalls at random in slow mode
  always @(posedge clock) in_ready <= slow ? ($urandom % 4 != 0) : 1'b1;

  task automatic put(input logic [7:0] d, input logic e, input logic z);
    int k;
    out_valid <= 1'b1;
    out_data  <= d;
    out_eop   <= e;
    out_zlp   <= z;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (out_ready !== 1'b1 && k < 5000);
    if (k >= 5000) stuck = 1'b1;
  endtask : put

  // Frames carry no checksum; limit kept by the caller
  task automatic send_seg(input int n, input logic [7:0] pat);
    for (int i = 0; i < n; i++) begin
      put(pat + i[7:0], (i % 64 == 63) || (i == n - 1), 1'b0);
    end
    if (n % 64 == 0) put(8'h00, 1'b1, 1'b1);
    out_valid <= 1'b0;
    out_eop   <= 1'b0;
    out_zlp   <= 1'b0;
    out_data  <= ~out_data;
    @(posedge clock);
  endtask : send_seg
endmodule : usp_host_model

/* testbench/usp_segment_pipe_test.sv */
`include "usp_consts.svh"
module usp_segment_pipe_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, nrst = 1'b0, iso_mode = 1'b0, slow = 1'b0;
  logic [1:0] alt_setting = 2'h0;
  logic [10:0] seg_limit = 11'h05EA, seg_exp = 11'h05EA, stat_len, seg_max;
  logic rx_valid = 1'b0, rx_last = 1'b0, tx_ready = 1'b0;
  logic [7:0] rx_data = 8'h00, in_data, out_data, tx_data, data_protocol;
  logic in_valid, in_last, in_zlp, in_ready, out_valid, out_eop, out_zlp, out_ready, stuck;
  logic tx_valid, tx_last, notify_conn, notify_speed, out_stall, iso_err, stat_valid, stat_good;
  logic [15:0] stat_frames, stat_drops, exp_good = 16'h0000, exp_drop = 16'h0000;
  logic [9:0] in_q[$];
  logic [8:0] tx_q[$];
  logic [1:0] ovf_q[$];
  logic [11:0] st_q[$], e;
  int err_total = 0, n_compared = 0;
  int rx_len[8] = '{5, 1, 63, 64, 65, 128, 200, 1514};
  int out_len[6] = '{3, 63, 64, 65, 128, 0};
  logic [10:0] lim_in[4] = '{11'h0064, 11'h07D0, 11'h05EE, 11'h05EA};
  logic [10:0] lim_ex[4] = '{11'h05EA, 11'h05FC, 11'h05EE, 11'h05EA};

  always #5 clock = ~clock;
  always @(posedge clock) tx_ready <= $urandom % 3 != 0;

  usp_segment_pipe u_usp_segment_pipe (.clock(clock), .nrst(nrst), .alt_setting(alt_setting),
    .iso_mode(iso_mode), .seg_limit(seg_limit), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_zlp(in_zlp),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_eop(out_eop),
    .out_zlp(out_zlp), .out_ready(out_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .data_protocol(data_protocol), .seg_max(seg_max),
    .notify_conn(notify_conn), .notify_speed(notify_speed), .out_stall(out_stall), .iso_err(iso_err),
    .stat_valid(stat_valid), .stat_len(stat_len), .stat_good(stat_good), .stat_frames(stat_frames),
    .stat_drops(stat_drops));
  usp_host_model u_usp_host_model (.clock(clock), .slow(slow), .in_valid(in_valid),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_eop(out_eop),
    .out_zlp(out_zlp), .out_ready(out_ready), .stuck(stuck));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ `USP_CRC_POLY) : (c >> 1);
    return c;
  endfunction : crc8

  // Results are compared as they appear; queues hold the notes
  always @(posedge clock) begin
    if (nrst && in_valid === 1'b1 && in_ready === 1'b1)
      check("in element", {in_zlp, in_last, in_data}, in_q.size() ? in_q.pop_front() : 'x);
    if (nrst && tx_valid === 1'b1 && tx_ready === 1'b1)
      check("tx byte", {tx_last, tx_data}, tx_q.size() ? tx_q.pop_front() : 'x);
    if (nrst && stat_valid === 1'b1) begin
      e = st_q.size() ? st_q.pop_front() : 'x;
      check("stat good", stat_good, e[11]);
      if (e[11] === 1'b1) check("stat len", stat_len, e[10:0]);
    end
    if (nrst && (out_stall || iso_err) === 1'b1)
      check("ovf flag", {out_stall, iso_err}, ovf_q.size() ? ovf_q.pop_front() : 'x);
    if (stuck) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic drain(input string name);
    int k;
    k = 0;
    while ((in_q.size() || tx_q.size() || st_q.size() || ovf_q.size()) && k < 20000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 20000) begin
      err_total++;
      tally_and_finish();
    end
    repeat (4) @(posedge clock);
    check("good count", stat_frames, exp_good);
    check("drop count", stat_drops, exp_drop);
    $display("test %s done", name);
  endtask : drain

  task automatic rx_frame(input int n, input logic [7:0] pat, input logic bad);
    logic [31:0] c;
    logic good;
    c = `USP_CRC_INIT;
    good = !bad && n >= 1 && n <= int'(seg_exp);
    st_q.push_back({good, n[10:0]});
    if (good) exp_good++;
    else exp_drop++;
    for (int i = 0; i < n && good; i++) in_q.push_back({1'b0, (i % 64 == 63) || (i == n - 1), pat + i[7:0]});
    if (good && n % 64 == 0) in_q.push_back(10'h300);
    for (int i = 0; i < n + 4; i++) begin
      if (i == n) c = ~c ^ {bad, 31'h0};
      rx_valid <= 1'b1;
      rx_data  <= (i < n) ? pat + i[7:0] : c[8*(i-n) +: 8];
      rx_last  <= (i == n + 3);
      if (i < n) c = crc8(c, pat + i[7:0]);
      @(posedge clock);
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    @(posedge clock);
  endtask : rx_frame

  task automatic select_alt(input logic [1:0] s);
    int k;
    alt_setting <= s;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (notify_conn !== 1'b1 && k < 8);
    check("notify conn", notify_conn, 1'b1);
    check("notify speed", notify_speed, 1'b1);
    exp_good = 16'h0000;
    exp_drop = 16'h0000;
  endtask : select_alt

  task automatic out_seg(input int n, input logic [7:0] pat);
    logic [31:0] c;
    c = `USP_CRC_INIT;
    for (int i = 0; i < n; i++) begin
      tx_q.push_back({1'b0, pat + i[7:0]});
      c = crc8(c, pat + i[7:0]);
    end
    for (int i = 0; i < 4 && n > 0; i++) tx_q.push_back({i == 3, ~c[8*i +: 8]});
    u_usp_host_model.send_seg(n, pat);
  endtask : out_seg

  initial begin
    void'($urandom(96));
    repeat (5) @(posedge clock);
    check("reset seg max", seg_max, 11'h05EA);
    check("reset out ready", out_ready, 1'b0);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    check("default out ready", out_ready, 1'b0);
    check("protocol", data_protocol, 8'h00);
    select_alt(2'h1);
    drain("activate");
    for (int i = 0; i < 4; i++) begin
      seg_limit <= lim_in[i];
      repeat (3) @(posedge clock);
      check("seg max", seg_max, lim_ex[i]);
    end
    for (int i = 0; i < 8; i++) begin
      slow <= i[0];
      rx_frame(rx_len[i], $urandom, 1'b0);
      drain("rx length");
    end
    rx_frame(100, $urandom, 1'b1);
    rx_frame(60, $urandom, 1'b0);
    rx_frame(1515, $urandom, 1'b0);
    drain("rx drops");
    seg_limit <= 11'h05EE;
    seg_exp = 11'h05EE;
    repeat (3) @(posedge clock);
    rx_frame(1518, $urandom, 1'b0);
    drain("rx long");
    for (int i = 0; i < 6; i++) out_seg(out_len[i], $urandom);
    for (int i = 0; i < 2; i++) begin
      iso_mode <= i[0];
      ovf_q.push_back({!i[0], i[0]});
      exp_drop++;
      u_usp_host_model.send_seg(1600, $urandom);
    end
    drain("out segments");
    alt_setting <= 2'h0;
    repeat (3) @(posedge clock);
    check("default out ready", out_ready, 1'b0);
    select_alt(2'h2);
    drain("reselect");
    tally_and_finish();
  end
endmodule : usp_segment_pipe_test

bind usp_segment_pipe usp_segment_pipe_chk u_chk (.clock(clock), .nrst(nrst), .alt_setting(alt_setting),
  .seg_limit(seg_limit), .rx_valid(rx_valid), .rx_last(rx_last), .in_valid(in_valid), .in_data(in_data),
  .in_last(in_last), .in_zlp(in_zlp), .in_ready(in_ready), .out_valid(out_valid), .out_eop(out_eop),
  .out_zlp(out_zlp), .out_ready(out_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .tx_ready(tx_ready), .data_protocol(data_protocol), .seg_max(seg_max), .notify_conn(notify_conn),
  .notify_speed(notify_speed), .stat_valid(stat_valid), .stat_frames(stat_frames), .stat_drops(stat_drops));
